// ==== core/hc_regs.svh ====
`ifndef HC_REGS_SVH
`define HC_REGS_SVH

// Register byte offsets on the APB port.
`define CAP_OFFSET 12'h008
`define CMD_OFFSET 12'h020
`define STS_OFFSET 12'h024

// Capability word fields and default contents.
`define CAP_PROG_FRAME_LIST_FLAG_BIT 1
`define CAP_ASYNC_PARK_CAPABLE_BIT 2
`define CAP_IST_LSB 4
`define CAP_ECP_LSB 8
`define CAP_ECP_RESET 8'h00
`define CAP_IST_RESET 4'h8
`define CAP_ASYNC_PARK_CAPABLE_RESET 1'b1
`define CAP_PROG_FRAME_LIST_FLAG_RESET 1'b1

// Command word fields and reset value.
`define CMD_RUN_BIT 0
`define CMD_FULL_RST_BIT 1
`define CMD_FLS_LSB 2
`define CMD_LIGHT_RST_BIT 7
`define CMD_RESET 32'h0008_0B00
`define CMD_LIGHT_CLR 32'h0000_0081

// Status word fields.
`define STS_PORT_BIT 2
`define STS_WRAP_BIT 3

// Frame index limits for each list length.
`define FIDX_MAX_1024 14'h1FFF
`define FIDX_MAX_512 14'h0FFF
`define FIDX_MAX_256 14'h07FF

// Timing: internal reset sequence length, rounded up to whole clocks.
`define CLK_PERIOD_PS 4000
`define RESET_TIME_NS 64
`define RESET_CYCLES ((`RESET_TIME_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

`endif

// ==== core/hc_pkg.sv ====
package hc_pkg;
	typedef enum logic [1:0] {SEQ_IDLE, SEQ_BUSY, SEQ_DONE} seq_state_type;
	typedef enum logic [1:0] {LIST_1024, LIST_512, LIST_256, LIST_RSVD} list_size_type;
endpackage : hc_pkg

// ==== core/hc_seq_if.sv ====
interface hc_seq_if;
	logic start;
	logic busy;
	logic done;
	modport ctrl (output start, input busy, input done);
	modport seq (input start, output busy, output done);
endinterface : hc_seq_if

// ==== core/reset_seq.sv ====
`include "hc_regs.svh"

module reset_seq #(
	parameter int unsigned CYCLES = `RESET_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	hc_seq_if.seq link
);
	localparam int CW = $clog2(CYCLES + 1);

	hc_pkg::seq_state_type state_q;
	hc_pkg::seq_state_type state_d;
	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		case (state_q)
			hc_pkg::SEQ_IDLE: begin
				if (link.start) begin
					state_d = hc_pkg::SEQ_BUSY;
					cnt_d = CW'(CYCLES - 1);
				end
			end
			hc_pkg::SEQ_BUSY: begin
				if (cnt_q == '0) begin
					state_d = hc_pkg::SEQ_DONE;
				end else begin
					cnt_d = cnt_q - CW'(1);
				end
			end
			hc_pkg::SEQ_DONE: state_d = hc_pkg::SEQ_IDLE;
			default: state_d = hc_pkg::SEQ_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= hc_pkg::SEQ_IDLE;
			cnt_q <= '0;
		end else if (ce) begin
			state_q <= state_d;
			cnt_q <= cnt_d;
		end
	end

	assign link.busy = (state_q != hc_pkg::SEQ_IDLE);
	assign link.done = (state_q == hc_pkg::SEQ_DONE);
endmodule : reset_seq

// ==== core/sticky_flag.sv ====
module sticky_flag #(
	parameter bit RESET_VAL = 1'b0
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic set,
	input wire logic clr,
	output logic flag
);
	logic flag_q;
	logic flag_d;

	// An event in the same cycle as a clear is kept.
	assign flag_d = set | (flag_q & ~clr);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_q <= RESET_VAL;
		end else if (ce) begin
			flag_q <= flag_d;
		end
	end

	assign flag = flag_q;
endmodule : sticky_flag

// ==== core/ehci_cap_cmd_status_regs.sv ====
// Decided for this implementation: the APB register port.
`include "hc_regs.svh"

// Function
// R1: Capability bits 15:8 give extension pointer.
// R2: Capability bits 7:4 give isochronous threshold.
// R3: Capability bit 2 reports park support.
// R4: Flag zero means software uses 1024 entries.
// R5: Flag one lets software shorten list size.
// R6: Each command write acts on new bits.
// R7: Light reset resets core, keeps port state.
// R8: Light reset bit reads zero when absent.
// R9: Full reset bit resets the controller.
// R10: Run bit runs schedules, clear halts them.
// R11: Software writes reserved bits with reset values.
// R12: Status word shows pending events and state; here it holds only the wrap and port event flags.
// R13: Status bits clear on written one only; here a core reset clears them too.
// R14: No transaction outcome in status word.
// R15: Frame index rollover sets status bit 3.
// R16: Port change or resume sets status bit 2.
// R17: Full reset bit self-clears when done.
module ehci_cap_cmd_status_regs #(
	parameter logic [7:0] EXT_CAP_PTR = `CAP_ECP_RESET,
	parameter logic [3:0] ISO_SCHED_THRESHOLD = `CAP_IST_RESET,
	parameter bit ASYNC_PARK_CAPABLE = `CAP_ASYNC_PARK_CAPABLE_RESET,
	parameter bit PROG_FRAME_LIST_FLAG = `CAP_PROG_FRAME_LIST_FLAG_RESET,
	parameter bit HAS_LIGHT_RESET = 1'b1,
	parameter int unsigned RESET_CYCLES = `RESET_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic uframe_tick,
	input wire logic port_change_evt,
	input wire logic resume_evt,
	output logic schedule_run,
	output logic core_reset,
	output logic port_reset,
	output logic cmd_strobe,
	output logic [1:0] frame_list_size,
	output logic [13:0] frame_index
);
	localparam int RST_CYC = RESET_CYCLES;

	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic [31:0] cmd_q;
	logic [31:0] cmd_d;
	logic [13:0] fidx_q;
	logic [13:0] fidx_d;
	logic sched_q;
	logic core_rst_q;
	logic port_rst_q;
	logic strobe_q;
	logic [1:0] size_q;

	logic setup;
	logic access;
	logic hit_cap;
	logic hit_cmd;
	logic hit_sts;
	logic hit_any;
	logic wr_cmd;
	logic wr_sts;
	logic [31:0] cap_word;
	logic [31:0] cmd_read;
	logic [31:0] sts_read;
	logic [31:0] rd_word;
	logic [31:0] cmd_wr_val;
	logic [31:0] cmd_base;
	logic core_busy;
	logic run_eff;
	logic tick_run;
	logic wrap_evt;
	logic port_evt;
	logic wrap_flag;
	logic port_flag;
	logic [13:0] fidx_max;
	hc_pkg::list_size_type size_eff;

	hc_seq_if full_if ();
	hc_seq_if light_if ();

	// APB decode. Every transfer is answered in its first access cycle.
	assign setup = psel & ~penable;
	assign access = psel & penable & pready_q;
	assign hit_cap = (paddr == `CAP_OFFSET);
	assign hit_cmd = (paddr == `CMD_OFFSET);
	assign hit_sts = (paddr == `STS_OFFSET);
	assign hit_any = hit_cap | hit_cmd | hit_sts;
	assign wr_cmd = access & pwrite & hit_cmd;
	assign wr_sts = access & pwrite & hit_sts;

	// Fixed capability contents; the whole word is read-only.
	assign cap_word = {16'h0000, EXT_CAP_PTR, ISO_SCHED_THRESHOLD, 1'b0, // see R1 see R2
		ASYNC_PARK_CAPABLE, PROG_FRAME_LIST_FLAG, 1'b0}; // see R3 see R4

	assign cmd_read = {cmd_q[31:8], cmd_q[7] & HAS_LIGHT_RESET, cmd_q[6:0]}; // see R8

	// Only controller events live here; per-transfer results are kept elsewhere.
	assign sts_read = {28'h0000000, wrap_flag, port_flag, 2'b00}; // see R12 see R14

	assign rd_word = hit_cap ? cap_word :
		hit_cmd ? cmd_read :
		hit_sts ? sts_read : 32'h0000_0000;

	// Read data is captured at setup, so the access cycle only has to present it.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else if (ce) begin
			pready_q <= setup;
			pslverr_q <= setup & ~hit_any;
			prdata_q <= (setup & ~pwrite) ? rd_word : 32'h0000_0000;
		end
	end

	// Reset sequencers. A full reset outranks a light one written alongside it.
	assign full_if.start = wr_cmd & pwdata[`CMD_FULL_RST_BIT] & ~full_if.busy; // see R9
	assign light_if.start = wr_cmd & pwdata[`CMD_LIGHT_RST_BIT] & HAS_LIGHT_RESET // see R7
		& ~pwdata[`CMD_FULL_RST_BIT] & ~full_if.busy & ~light_if.busy;
	assign core_busy = full_if.busy | light_if.busy;

	// The sequencers share the clock enable, so a freeze stretches a reset sequence
	// instead of letting it finish while the rest of the block is held.
	reset_seq #(
		.CYCLES(RESET_CYCLES)
	) u_full_seq (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.link(full_if.seq)
	);

	reset_seq #(
		.CYCLES(RESET_CYCLES)
	) u_light_seq (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.link(light_if.seq)
	);

	// Reset bits stay set while their sequence runs, so software can poll them.
	assign cmd_wr_val = {pwdata[31:8],
		(pwdata[`CMD_LIGHT_RST_BIT] & HAS_LIGHT_RESET) | light_if.busy,
		pwdata[6:2],
		pwdata[`CMD_FULL_RST_BIT] | full_if.busy,
		pwdata[`CMD_RUN_BIT]}; // see R6
	assign cmd_base = wr_cmd ? cmd_wr_val : cmd_q;
	assign cmd_d = full_if.done ? `CMD_RESET : // see R17 see R9
		light_if.done ? (cmd_base & ~`CMD_LIGHT_CLR) : cmd_base; // see R7

	// Without the programmable flag the list length is pinned at 1024.
	assign size_eff = PROG_FRAME_LIST_FLAG ?
		hc_pkg::list_size_type'(cmd_q[`CMD_FLS_LSB +: 2]) : hc_pkg::LIST_1024; // see R5 see R4
	assign fidx_max = (size_eff == hc_pkg::LIST_512) ? `FIDX_MAX_512 :
		(size_eff == hc_pkg::LIST_256) ? `FIDX_MAX_256 : `FIDX_MAX_1024;

	assign run_eff = cmd_q[`CMD_RUN_BIT] & ~core_busy; // see R10
	assign tick_run = uframe_tick & run_eff;
	// A shrunk list may leave the index above the new limit; >= wraps it on the next running tick.
	assign wrap_evt = tick_run & (fidx_q >= fidx_max); // see R15
	assign fidx_d = core_busy ? 14'h0000 :
		wrap_evt ? 14'h0000 :
		tick_run ? fidx_q + 14'h0001 : fidx_q;
	assign port_evt = (port_change_evt | resume_evt) & ~core_busy; // see R16

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_q <= `CMD_RESET;
			fidx_q <= 14'h0000;
			sched_q <= 1'b0;
			core_rst_q <= 1'b0;
			port_rst_q <= 1'b0;
			strobe_q <= 1'b0;
			size_q <= 2'h0;
		end else if (ce) begin
			cmd_q <= cmd_d;
			fidx_q <= fidx_d;
			sched_q <= run_eff;
			core_rst_q <= core_busy;
			port_rst_q <= full_if.busy;
			strobe_q <= wr_cmd;
			size_q <= size_eff;
		end
	end

	// Status flags are cleared by a written one, or by a core reset.
	sticky_flag #(
		.RESET_VAL(1'b0)
	) u_wrap_flag (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.set(wrap_evt),
		.clr((wr_sts & pwdata[`STS_WRAP_BIT]) | core_busy), // see R13
		.flag(wrap_flag)
	);

	sticky_flag #(
		.RESET_VAL(1'b0)
	) u_port_flag (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.set(port_evt),
		.clr((wr_sts & pwdata[`STS_PORT_BIT]) | core_busy), // see R13
		.flag(port_flag)
	);

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign schedule_run = sched_q;
	assign core_reset = core_rst_q;
	assign port_reset = port_rst_q;
	assign cmd_strobe = strobe_q;
	assign frame_list_size = size_q;
	assign frame_index = fidx_q;

	default clocking cb @(posedge pclk);
	endclocking
	// Checks pause during reset and while frozen, since nothing may move then.
	default disable iff (!presetn || !ce);

	a_cap_pointer: assert property (setup && hit_cap && !pwrite |=> prdata[15:8] == EXT_CAP_PTR) // see R1
		else $error("extension pointer field wrong");
	a_cap_threshold: assert property (setup && hit_cap && !pwrite |=> prdata[7:4] == ISO_SCHED_THRESHOLD) // see R2
		else $error("threshold field wrong");
	a_cap_park: assert property (setup && hit_cap && !pwrite |=> prdata[2] == ASYNC_PARK_CAPABLE) // see R3
		else $error("park bit wrong");
	a_list_size: assert property (wr_cmd && !core_busy |-> ##2 // see R5
		(frame_list_size == (PROG_FRAME_LIST_FLAG ? $past(pwdata[3:2], 2) : 2'h0)))
		else $error("list size not taken from command");
	a_cmd_strobe: assert property (wr_cmd |=> cmd_strobe) // see R6
		else $error("command write not acted on");
	a_light_core: assert property (light_if.start |=> ##1 core_reset && !port_reset) // see R7
		else $error("light reset touched ports");
	a_light_absent: assert property (!HAS_LIGHT_RESET && setup && hit_cmd && !pwrite |=> !prdata[7]) // see R8
		else $error("absent light reset reads one");
	a_full_length: assert property (full_if.start |-> ##(RST_CYC + 1) cmd_q[1] ##1 !cmd_q[1]) // see R17
		else $error("full reset bit timing wrong");
	a_full_ports: assert property (full_if.start |=> ##1 port_reset && core_reset) // see R9
		else $error("full reset did not reset");
	a_run_halt: assert property (!cmd_q[0] |=> !schedule_run) // see R10
		else $error("schedules run while stopped");
	a_clear_one: assert property (wr_sts && pwdata[3] && !wrap_evt |=> !wrap_flag) // see R13
		else $error("written one did not clear");
	a_keep_zero: assert property (wr_sts && !pwdata[2] && port_flag && !core_busy |=> port_flag) // see R13
		else $error("written zero cleared flag");
	a_wrap_sets: assert property (wrap_evt |=> wrap_flag && frame_index == 14'h0000) // see R15
		else $error("rollover not flagged");
	a_port_sets: assert property (port_evt |=> port_flag) // see R16
		else $error("port change not flagged");

	// Read-back of the fixed and sticky words; reserved bits must never leak state.
	a_cap_prog: assert property (setup && hit_cap && !pwrite |=> prdata[1] == PROG_FRAME_LIST_FLAG) // see R5
		else $error("list flag wrong");
	a_cap_reserved: assert property (setup && hit_cap && !pwrite |=> // see R1
		prdata[31:16] == 16'h0000 && !prdata[3] && !prdata[0])
		else $error("capability reserved bits set");
	a_fixed_size: assert property (!PROG_FRAME_LIST_FLAG |-> frame_list_size == 2'h0) // see R4
		else $error("list size not pinned");
	a_sts_read: assert property (setup && hit_sts && !pwrite |=> prdata[3:2] == $past({wrap_flag, port_flag})) // see R12
		else $error("status read-back wrong");
	a_sts_reserved: assert property (setup && hit_sts && !pwrite |=> // see R14
		prdata[31:4] == 28'h0000000 && prdata[1:0] == 2'b00)
		else $error("status reserved bits set");

	// Schedule and reset sequencing.
	a_run_go: assert property (cmd_q[0] && !core_busy |=> schedule_run) // see R10
		else $error("schedules halted while running");
	a_halt_index: assert property (!run_eff && !core_busy |=> $stable(frame_index)) // see R10
		else $error("index moved while stopped");
	a_core_held: assert property (core_busy |=> core_reset && !schedule_run) // see R9
		else $error("core not held in reset");
	a_reset_index: assert property (core_busy |=> frame_index == 14'h0000 && !wrap_flag && !port_flag) // see R9
		else $error("reset left index or flags");
	a_full_clears: assert property (full_if.done |=> cmd_q == `CMD_RESET) // see R17
		else $error("full reset left command bits");
	a_light_clears: assert property (light_if.done |=> !cmd_q[7] && !cmd_q[0]) // see R7
		else $error("light reset left run or reset bit");
	a_light_ports: assert property (light_if.busy && !full_if.busy |=> !port_reset) // see R7
		else $error("light reset reached the ports");
	a_strobe_once: assert property (cmd_strobe |=> !cmd_strobe) // see R6
		else $error("command strobe stretched");

	c_full_reset: cover property (full_if.start ##[1:40] full_if.done);
	c_light_reset: cover property (light_if.start ##[1:40] light_if.done);
	c_rollover: cover property (wrap_evt);
	c_w1c_race: cover property (wr_sts && pwdata[2] && port_evt);
	c_list_resize: cover property (wr_cmd && pwdata[3:2] != cmd_q[3:2]);
endmodule : ehci_cap_cmd_status_regs

// ==== dv/testbench.sv ====
`include "hc_regs.svh"

module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] PTR = 8'hA5;
	localparam logic [3:0] THR = 4'h3;
	typedef struct {logic [31:0] data; logic err; string what;} note_type;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic ce = 1'b1;
	logic [31:0] prdata_fx;
	logic [1:0] frame_list_size_fx;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic uframe_tick = 1'b0;
	logic port_change_evt = 1'b0;
	logic resume_evt = 1'b0;
	logic schedule_run;
	logic core_reset;
	logic port_reset;
	logic cmd_strobe;
	logic [1:0] frame_list_size;
	logic [13:0] frame_index;
	logic [7:0] lfsr_q = 8'h2B;
	int error_cnt = 0;
	int num_checks = 0;
	int cycles = 0;
	int strobes = 0;
	int cmd_writes = 0;
	int n;
	note_type notes[$];

	ehci_cap_cmd_status_regs #(.EXT_CAP_PTR(PTR), .ISO_SCHED_THRESHOLD(THR), .RESET_CYCLES(2)) dut (
		.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.uframe_tick(uframe_tick), .port_change_evt(port_change_evt), .resume_evt(resume_evt),
		.schedule_run(schedule_run), .core_reset(core_reset), .port_reset(port_reset),
		.cmd_strobe(cmd_strobe), .frame_list_size(frame_list_size), .frame_index(frame_index));

	// Second copy without light reset or list choice; it shares every input with dut.
	ehci_cap_cmd_status_regs #(.ISO_SCHED_THRESHOLD(THR), .PROG_FRAME_LIST_FLAG(1'b0), .HAS_LIGHT_RESET(1'b0),
		.RESET_CYCLES(2)) dut_fixed (
		.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata_fx), .pready(), .pslverr(),
		.uframe_tick(uframe_tick), .port_change_evt(port_change_evt), .resume_evt(resume_evt),
		.schedule_run(), .core_reset(), .port_reset(),
		.cmd_strobe(), .frame_list_size(frame_list_size_fx), .frame_index());

	always #2 pclk = ~pclk;

	function automatic logic [7:0] lfsr_next(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction : lfsr_next

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks = num_checks + 1;
		if (got !== exp) begin
			error_cnt = error_cnt + 1;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : tally_and_finish

	// Called just after a rising edge; the expected answer is queued before the request goes out.
	task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data,
		input logic [31:0] exp, input logic err, input string what);
		notes.push_back('{exp, err, what});
		if (wr && addr == `CMD_OFFSET) cmd_writes = cmd_writes + 1;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= data;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic wait_reset(input logic level);
		while (core_reset !== level) @(posedge pclk);
	endtask : wait_reset

	// The answer is judged at the edge where the master samples pready, as a real master would.
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cmd_strobe === 1'b1) strobes <= strobes + 1;
		if (psel && penable && pready === 1'b1 && notes.size() > 0) begin
			check(notes[0].what, notes[0].data, prdata);
			check({notes[0].what, " err"}, 32'(notes[0].err), 32'(pslverr));
			check({notes[0].what, " fixed"}, 32'h0, 32'(prdata_fx[7]));
			void'(notes.pop_front());
		end
		if (cycles == 20000) begin
			error_cnt = error_cnt + 1;
			tally_and_finish();
		end
	end

	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		check("run idle", 32'h0, 32'(schedule_run));
		apb(1'b1, `CAP_OFFSET, 32'hFFFF_FFFF, 32'h0, 1'b0, "cap wr");
		apb(1'b0, `CAP_OFFSET, 32'h0, {16'h0000, PTR, THR, 1'b0, 1'b1, 1'b1, 1'b0}, 1'b0, "cap");
		apb(1'b0, `CMD_OFFSET, 32'h0, `CMD_RESET, 1'b0, "cmd rst");
		apb(1'b0, `STS_OFFSET, 32'h0, 32'h0, 1'b0, "sts rst");
		apb(1'b1, 12'h010, 32'h0000_0001, 32'h0, 1'b1, "bad wr");
		apb(1'b0, 12'h010, 32'h0, 32'h0, 1'b1, "bad rd");
		apb(1'b1, `CMD_OFFSET, `CMD_RESET | 32'h0000_0009, 32'h0, 1'b0, "cmd wr");
		repeat (2) @(posedge pclk);
		check("strobes", 32'(cmd_writes), 32'(strobes));
		check("run", 32'h1, 32'(schedule_run));
		check("list", 32'h2, 32'(frame_list_size));
		check("list fixed", 32'h0, 32'(frame_list_size_fx));
		apb(1'b0, `CMD_OFFSET, 32'h0, `CMD_RESET | 32'h0000_0009, 1'b0, "cmd rd");
		// Ticks offered while the clock enable is low must not move the index.
		ce <= 1'b0;
		uframe_tick <= 1'b1;
		repeat (3) @(posedge pclk);
		ce <= 1'b1;
		uframe_tick <= 1'b0;
		@(posedge pclk);
		// Random tick spacing; the list of 256 entries wraps after 8 * 256 ticks.
		n = 0;
		while (n < 2047) begin
			lfsr_q = lfsr_next(lfsr_q);
			uframe_tick <= lfsr_q[0];
			n = n + 32'(lfsr_q[0]);
			@(posedge pclk);
		end
		uframe_tick <= 1'b0;
		@(posedge pclk);
		check("index max", 32'h0000_07FF, 32'(frame_index));
		apb(1'b0, `STS_OFFSET, 32'h0, 32'h0, 1'b0, "no wrap");
		uframe_tick <= 1'b1;
		@(posedge pclk);
		uframe_tick <= 1'b0;
		repeat (2) @(posedge pclk);
		check("index wrap", 32'h0, 32'(frame_index));
		apb(1'b0, `STS_OFFSET, 32'h0, 32'h0000_0008, 1'b0, "wrap");
		apb(1'b1, `STS_OFFSET, 32'h0, 32'h0, 1'b0, "w0");
		apb(1'b0, `STS_OFFSET, 32'h0, 32'h0000_0008, 1'b0, "kept");
		apb(1'b1, `STS_OFFSET, 32'h0000_0008, 32'h0, 1'b0, "w1");
		apb(1'b0, `STS_OFFSET, 32'h0, 32'h0, 1'b0, "clr");
		for (int i = 0; i < 2; i++) begin
			{resume_evt, port_change_evt} <= 2'b01 << i;
			@(posedge pclk);
			{resume_evt, port_change_evt} <= 2'b00;
			@(posedge pclk);
			apb(1'b0, `STS_OFFSET, 32'h0, 32'h0000_0004, 1'b0, "port");
			apb(1'b1, `STS_OFFSET, 32'h0000_0004, 32'h0, 1'b0, "w1p");
		end
		apb(1'b1, `CMD_OFFSET, `CMD_RESET | 32'h0000_0089, 32'h0, 1'b0, "light");
		wait_reset(1'b1);
		check("port keep", 32'h0, 32'(port_reset));
		check("halt", 32'h0, 32'(schedule_run));
		wait_reset(1'b0);
		apb(1'b0, `CMD_OFFSET, 32'h0, `CMD_RESET | 32'h0000_0008, 1'b0, "light end");
		port_change_evt <= 1'b1;
		@(posedge pclk);
		port_change_evt <= 1'b0;
		apb(1'b1, `CMD_OFFSET, `CMD_RESET | 32'h0000_000B, 32'h0, 1'b0, "full");
		wait_reset(1'b1);
		check("port rst", 32'h1, 32'(port_reset));
		wait_reset(1'b0);
		apb(1'b0, `CMD_OFFSET, 32'h0, `CMD_RESET, 1'b0, "full end");
		apb(1'b0, `STS_OFFSET, 32'h0, 32'h0, 1'b0, "sts clr");
		check("list rst", 32'h0, 32'(frame_list_size));
		check("run rst", 32'h0, 32'(schedule_run));
		check("strobes end", 32'(cmd_writes), 32'(strobes));
		tally_and_finish();
	end
endmodule : testbench
